// [prsi_init_state.v]
// Processor reset and initialization state loader with APB register access
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "prsi_defines.vh"

// Overview of operation
// - Start in 16-bit real mode after reset/init
// - Code selector F000h, base FFFF_0000h directly
// - Instruction pointer FFF0h, fetch at base plus pointer
// - Code base holds until software loads selector
// - Real-mode selector load: base is selector shifted four
// - Fetch address is base plus pointer, pointer cut to 16 bits in real mode
// - Hard reset loads control 6000_0010h
// - Init keeps cache-disable, no-writethrough; sets bit 4
// - Accumulator zero, non-zero on failed self-test at hard reset
// - Identity value placed in data register
// - Other general-purpose registers cleared to zero
// - Hard reset only sets floating-point state
// - Hard reset sets management base 0003_0000h
// - Hard reset invalidates caches; init does not
// - Init keeps priority, fp, stamp, management base
// - Flags, debug status and control reset values
// - Hidden segment attributes set by reset/init
// - Multiprocessor: negotiate one bootstrap, others wait
// - Cycle stamp cleared on reset, counts every cycle
// - Stepping bits 3-0, model bits 7-4
module prsi_init_state #(
    parameter [3:0] ID_STEPPING  = 4'h1,
    parameter [3:0] ID_MODEL     = 4'h2,
    parameter [3:0] ID_FAMILY    = 4'h3,
    parameter [3:0] ID_EXT_MODEL = 4'h0,
    parameter [7:0] ID_EXT_FAM   = 8'h00,
    parameter [3:0] CPU_INDEX    = 4'h0,
    parameter [3:0] ARB_BASE     = 4'h2
) (
    // Clock and hard reset
    input  wire        clk,
    input  wire        reset,
    // Soft initialization pin and self-test result
    input  wire        init_req,
    input  wire        builtin_self_test_fail,
    // Bootstrap negotiation pins
    input  wire        bsp_claim_in,
    input  wire        ap_start,
    output wire        bsp_claim_out,
    // Fetch port
    output wire        fetch_req,
    output reg  [31:0] fetch_addr_r,
    input  wire        fetch_done,
    input  wire [31:0] fetch_next_ip,
    input  wire        cs_load,
    input  wire [15:0] cs_load_sel,
    // Mode and memory hierarchy
    output wire        real_mode,
    output reg         cache_inval_r,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam ST_HOLD  = 3'd0;
    localparam ST_ARB   = 3'd1;
    localparam ST_BSP   = 3'd2;
    localparam ST_APW   = 3'd3;
    localparam ST_AP    = 3'd4;

    reg  [31:0] cr0_r, cr2_r, cr3_r, cr4_r, tpr_r, flags_r, extended_feature_reg_r, ip_r;
    reg  [15:0] cs_sel_r;
    reg  [31:0] cs_base_r, dr6_r, dr7_r, mgmt_memory_base_r;
    reg  [31:0] dr_r [0:3];
    reg  [63:0] tsc_r;
    reg  [15:0] fcw_r, fsw_r, ftw_r;
    reg  [31:0] fptr_r;
    reg  [2:0]  sync1_r, sync2_r, sync3_r, lvl_r;
    reg  [2:0]  st_r;
    reg  [3:0]  arb_cnt_r;
    reg  [31:0] prdata_r;
    reg         gpr_rd_r;
    reg  [31:0] rd_mux;
    reg         rd_hit;
    wire [31:0] mem_rdata;
    wire        init_lvl;
    wire        claim_lvl;
    wire        start_lvl;
    wire        loading;
    wire        wr_en;
    wire        setup_rd;
    wire        gpr_hit;
    wire        addr_ok;
    wire [8:0]  a9;
    integer     k;

    assign init_lvl  = lvl_r[0];
    assign claim_lvl = lvl_r[1];
    assign start_lvl = lvl_r[2];
    assign loading   = reset | init_lvl;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function [31:0] id_value;
        input dummy;
        begin
            id_value = `PRSI_ZERO32;
            id_value[`PRSI_ID_STEP_LSB +: 4]  = ID_STEPPING;
            id_value[`PRSI_ID_MODEL_LSB +: 4] = ID_MODEL;
            id_value[`PRSI_ID_FAM_LSB +: 4]   = ID_FAMILY;
            id_value[`PRSI_ID_EMOD_LSB +: 4]  = ID_EXT_MODEL;
            id_value[`PRSI_ID_EFAM_LSB +: 8]  = ID_EXT_FAM;
        end
    endfunction

    function [31:0] real_base;
        input [15:0] sel;
        begin
            real_base = {12'h000, sel, 4'h0} & ({32{1'b1}} >> (16 - `PRSI_SEG_SHIFT));
        end
    endfunction

    // State shared by hard reset and soft initialization
    task load_common;
        begin
            cr2_r     <= `PRSI_ZERO32;
            cr3_r     <= `PRSI_ZERO32;
            cr4_r     <= `PRSI_ZERO32;
            extended_feature_reg_r    <= `PRSI_ZERO32;
            flags_r   <= `PRSI_FLAGS_RST;
            dr6_r     <= `PRSI_DR6_RST;
            dr7_r     <= `PRSI_DR7_RST;
            for (k = 0; k < 4; k = k + 1) begin
                dr_r[k] <= `PRSI_ZERO32;
            end
            cs_sel_r  <= `PRSI_CS_SEL_RST;
            cs_base_r <= `PRSI_CS_BASE_RST;
            ip_r      <= `PRSI_IP_RST;
        end
    endtask

    // ------------------------------------------------------------------------
    // Pin synchronisers: a change counts once stages two and three agree
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        sync1_r <= {ap_start, bsp_claim_in, init_req};
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        if (reset) begin
            lvl_r <= 3'b000;
        end else begin
            lvl_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (lvl_r & (sync2_r ^ sync3_r));
        end
    end

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    assign a9       = paddr[8:0];
    assign addr_ok  = (paddr[11:9] == 3'b000);
    assign gpr_hit  = addr_ok & a9[8] & ~a9[7];
    assign wr_en    = psel & penable & pwrite & ~pslverr;
    assign setup_rd = psel & ~penable & ~pwrite;
    // Zero-wait slave; reads are captured in setup so the access phase serves them
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~(rd_hit | gpr_hit);
    assign prdata   = gpr_rd_r ? mem_rdata : prdata_r;

    always @* begin
        rd_hit = addr_ok;
        case (a9)
            `PRSI_A_CR0:     rd_mux = cr0_r;
            `PRSI_A_CR2:     rd_mux = cr2_r;
            `PRSI_A_CR3:     rd_mux = cr3_r;
            `PRSI_A_CR4:     rd_mux = cr4_r;
            `PRSI_A_TPR:     rd_mux = tpr_r;
            `PRSI_A_FLAGS:   rd_mux = flags_r;
            `PRSI_A_EXTENDED_FEATURE_REG:    rd_mux = extended_feature_reg_r;
            `PRSI_A_IP:      rd_mux = ip_r;
            `PRSI_A_CS_SEL:  rd_mux = {16'h0000, cs_sel_r};
            `PRSI_A_CS_BASE: rd_mux = cs_base_r;
            `PRSI_A_DR6:     rd_mux = dr6_r;
            `PRSI_A_DR7:     rd_mux = dr7_r;
            `PRSI_A_DR0:     rd_mux = dr_r[0];
            `PRSI_A_DR1:     rd_mux = dr_r[1];
            `PRSI_A_DR2:     rd_mux = dr_r[2];
            `PRSI_A_DR3:     rd_mux = dr_r[3];
            `PRSI_A_MGMT_MEMORY_BASE:  rd_mux = mgmt_memory_base_r;
            `PRSI_A_TSC_LO:  rd_mux = tsc_r[31:0];
            `PRSI_A_TSC_HI:  rd_mux = tsc_r[63:32];
            `PRSI_A_FCW:     rd_mux = {16'h0000, fcw_r};
            `PRSI_A_FSW:     rd_mux = {16'h0000, fsw_r};
            `PRSI_A_FTW:     rd_mux = {16'h0000, ftw_r};
            `PRSI_A_STATUS:  rd_mux = {24'h00_0000, 1'b0, st_r, cache_inval_r, init_lvl, fetch_req, real_mode};
            `PRSI_A_SEGATTR: rd_mux = {`PRSI_ATTR_TSS, `PRSI_ATTR_LDT,
                                       `PRSI_ATTR_DATA, `PRSI_ATTR_CODE};
            default: begin
                rd_mux = `PRSI_ZERO32;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            prdata_r <= `PRSI_ZERO32;
            gpr_rd_r <= 1'b0;
        end else if (setup_rd) begin
            prdata_r <= rd_hit ? rd_mux : `PRSI_ZERO32;
            gpr_rd_r <= gpr_hit;
        end
    end

    // ------------------------------------------------------------------------
    // Architectural state
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            load_common;
            cr0_r    <= `PRSI_CR0_HARD;
            tpr_r    <= `PRSI_ZERO32;
            mgmt_memory_base_r <= `PRSI_MGMT_MEMORY_BASE_RST;
            fcw_r    <= `PRSI_FCW_RST;
            fsw_r    <= `PRSI_FSW_RST;
            ftw_r    <= `PRSI_FTW_RST;
            fptr_r   <= `PRSI_ZERO32;
        end else if (init_lvl) begin
            // Reloaded every cycle the pin is held, so values stand until release
            load_common;
            cr0_r <= (cr0_r & `PRSI_CR0_KEEP) | `PRSI_CR0_INIT;
            // Priority, fp state, stamp and management base are left alone
        end else begin
            if (wr_en) begin
                case (a9)
                    `PRSI_A_CR0:    cr0_r   <= pwdata;
                    `PRSI_A_CR2:    cr2_r   <= pwdata;
                    `PRSI_A_CR3:    cr3_r   <= pwdata;
                    `PRSI_A_CR4:    cr4_r   <= pwdata;
                    `PRSI_A_TPR:    tpr_r   <= pwdata;
                    `PRSI_A_FLAGS:  flags_r <= pwdata;
                    `PRSI_A_EXTENDED_FEATURE_REG:   extended_feature_reg_r  <= pwdata;
                    `PRSI_A_DR6:    dr6_r   <= pwdata;
                    `PRSI_A_DR7:    dr7_r   <= pwdata;
                    `PRSI_A_DR0:    dr_r[0] <= pwdata;
                    `PRSI_A_DR1:    dr_r[1] <= pwdata;
                    `PRSI_A_DR2:    dr_r[2] <= pwdata;
                    `PRSI_A_DR3:    dr_r[3] <= pwdata;
                    `PRSI_A_MGMT_MEMORY_BASE: mgmt_memory_base_r <= pwdata;
                    `PRSI_A_FCW:    fcw_r   <= pwdata[15:0];
                    `PRSI_A_FSW:    fsw_r   <= pwdata[15:0];
                    `PRSI_A_FTW:    ftw_r   <= pwdata[15:0];
                    default: begin
                    end
                endcase
            end
            // Core load wins over a register write of the same cycle
            if (cs_load) begin
                cs_sel_r <= cs_load_sel;
                if (real_mode) begin
                    cs_base_r <= real_base(cs_load_sel);
                end
            end else if (wr_en && a9 == `PRSI_A_CS_SEL) begin
                cs_sel_r <= pwdata[15:0];
                if (real_mode) begin
                    cs_base_r <= real_base(pwdata[15:0]);
                end
            end
            // Otherwise the start-up base stays put
            if (fetch_done) begin
                ip_r <= fetch_next_ip;
            end else if (wr_en && a9 == `PRSI_A_IP) begin
                ip_r <= pwdata;
            end
        end
    end

    // Counts through soft initialization; only hard reset clears it
    always @(posedge clk) begin
        if (reset) begin
            tsc_r <= 64'h0000_0000_0000_0000;
        end else begin
            tsc_r <= tsc_r + 64'h0000_0000_0000_0001;
        end
    end

    // Held high through reset, falls at the first edge after release
    always @(posedge clk) begin
        cache_inval_r <= reset;
    end

    assign real_mode = ~cr0_r[`PRSI_PE_BIT];

    // ------------------------------------------------------------------------
    // General-purpose registers
    // ------------------------------------------------------------------------
    prsi_gpr_mem #(
        .DW    (32),
        .AW    (5),
        .DEPTH (32)
    ) u_gpr (
        .clk     (clk),
        .clr     (loading),
        .clr_acc ((reset & builtin_self_test_fail) ? `PRSI_BUILTIN_SELF_TEST_CODE : `PRSI_ZERO32),
        .clr_id  (id_value(1'b0)),
        .we      (wr_en & gpr_hit),
        .waddr   (a9[6:2]),
        .wdata   (pwdata),
        .raddr   (a9[6:2]),
        .rdata_r (mem_rdata)
    );

    // ------------------------------------------------------------------------
    // Bootstrap negotiation and first fetch
    // ------------------------------------------------------------------------
    // Each processor waits its own slot; the first unchallenged one claims.
    // Limitation: ties resolve only if every processor has a distinct index.
    always @(posedge clk) begin
        if (loading) begin
            st_r      <= ST_HOLD;
            arb_cnt_r <= 4'h0;
        end else begin
            case (st_r)
                ST_HOLD: begin
                    st_r      <= ST_ARB;
                    arb_cnt_r <= ARB_BASE + CPU_INDEX;
                end
                ST_ARB: begin
                    if (claim_lvl) begin
                        st_r <= ST_APW;
                    end else if (arb_cnt_r == 4'h0) begin
                        st_r <= ST_BSP;
                    end else begin
                        arb_cnt_r <= arb_cnt_r - 4'h1;
                    end
                end
                ST_APW: begin
                    if (start_lvl) begin
                        st_r <= ST_AP;
                    end
                end
                ST_BSP, ST_AP: begin
                    st_r <= st_r;
                end
                default: begin
                    st_r <= ST_HOLD;
                end
            endcase
        end
    end

    assign bsp_claim_out = ~loading & (st_r == ST_BSP);
    assign fetch_req     = ~loading & ((st_r == ST_BSP) | (st_r == ST_AP));

    always @(posedge clk) begin
        if (real_mode) begin
            fetch_addr_r <= cs_base_r + (ip_r & `PRSI_REAL_IP_MASK);
        end else begin
            fetch_addr_r <= cs_base_r + ip_r;
        end
    end

endmodule

`default_nettype wire

// [prsi_defines.vh]
// Constants for the processor reset and initialization state block
`ifndef PRSI_DEFINES_VH
`define PRSI_DEFINES_VH

// ----------------------------------------------------------------------------
// Initial values
// ----------------------------------------------------------------------------
`define PRSI_CR0_HARD     32'h6000_0010
`define PRSI_CR0_INIT     32'h0000_0010
`define PRSI_CR0_KEEP     32'h6000_0000
`define PRSI_FLAGS_RST    32'h0000_0002
`define PRSI_DR6_RST      32'hFFFF_0FF0
`define PRSI_DR7_RST      32'h0000_0400
`define PRSI_CS_SEL_RST   16'hF000
`define PRSI_CS_BASE_RST  32'hFFFF_0000
`define PRSI_IP_RST       32'h0000_FFF0
`define PRSI_MGMT_MEMORY_BASE_RST   32'h0003_0000
`define PRSI_FCW_RST      16'h0040
`define PRSI_FSW_RST      16'h0000
`define PRSI_FTW_RST      16'h5555
`define PRSI_ZERO32       32'h0000_0000
`define PRSI_BUILTIN_SELF_TEST_CODE    32'h0000_0001
`define PRSI_REAL_IP_MASK 32'h0000_FFFF
`define PRSI_SEG_SHIFT    4
`define PRSI_PE_BIT       0

// ----------------------------------------------------------------------------
// Hidden attribute bytes {present, dpl[1:0], s, type[3:0]}
// ----------------------------------------------------------------------------
`define PRSI_ATTR_CODE    8'h9A
`define PRSI_ATTR_DATA    8'h92
`define PRSI_ATTR_LDT     8'h82
`define PRSI_ATTR_TSS     8'h83

// ----------------------------------------------------------------------------
// Identity value field positions
// ----------------------------------------------------------------------------
`define PRSI_ID_STEP_LSB  0
`define PRSI_ID_MODEL_LSB 4
`define PRSI_ID_FAM_LSB   8
`define PRSI_ID_EMOD_LSB  16
`define PRSI_ID_EFAM_LSB  20

// ----------------------------------------------------------------------------
// General-purpose store entries (low word of accumulator and data register)
// ----------------------------------------------------------------------------
`define PRSI_GPR_ACC_LO   5'h00
`define PRSI_GPR_RDX_LO   5'h04

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PRSI_A_CR0        9'h000
`define PRSI_A_CR2        9'h004
`define PRSI_A_CR3        9'h008
`define PRSI_A_CR4        9'h00C
`define PRSI_A_TPR        9'h010
`define PRSI_A_FLAGS      9'h014
`define PRSI_A_EXTENDED_FEATURE_REG       9'h018
`define PRSI_A_IP         9'h01C
`define PRSI_A_CS_SEL     9'h020
`define PRSI_A_CS_BASE    9'h024
`define PRSI_A_DR6        9'h028
`define PRSI_A_DR7        9'h02C
`define PRSI_A_DR0        9'h030
`define PRSI_A_DR1        9'h034
`define PRSI_A_DR2        9'h038
`define PRSI_A_DR3        9'h03C
`define PRSI_A_MGMT_MEMORY_BASE     9'h040
`define PRSI_A_TSC_LO     9'h044
`define PRSI_A_TSC_HI     9'h048
`define PRSI_A_FCW        9'h04C
`define PRSI_A_FSW        9'h050
`define PRSI_A_FTW        9'h054
`define PRSI_A_STATUS     9'h058
`define PRSI_A_SEGATTR    9'h05C

`endif

// [prsi_gpr_mem.v]
// General-purpose register store with clear-and-preload and registered read
`timescale 1ns/1ns
`default_nettype none

module prsi_gpr_mem #(
    parameter DW    = 32,
    parameter AW    = 5,
    parameter DEPTH = 32
) (
    // Clock
    input  wire          clk,
    // Clear with preload of two entries
    input  wire          clr,
    input  wire [DW-1:0] clr_acc,
    input  wire [DW-1:0] clr_id,
    // Write port
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    // Read port
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_r
);

    reg [DW-1:0] mem_r [0:DEPTH-1];
    integer      i;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // Clear is one wide cycle so the whole set is valid the edge reset ends
    always @(posedge clk) begin
        if (clr) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_r[i] <= {DW{1'b0}};
            end
            mem_r[`PRSI_GPR_ACC_LO] <= clr_acc;
            mem_r[`PRSI_GPR_RDX_LO] <= clr_id;
        end else if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always @(posedge clk) begin
        rdata_r <= mem_r[raddr];
    end

endmodule

`default_nettype wire

// [prsi_sys_model.sv]
// Model of the system logic on the init and bootstrap pins
`timescale 1ns/1ns
`default_nettype none
module prsi_sys_model (
    // Clock
    input  wire logic clk,
    // Pins toward the processor
    output var  logic init_req,
    output var  logic bsp_claim_in,
    output var  logic ap_start
);
    initial begin
        init_req = 1'b0;
        bsp_claim_in = 1'b0;
        ap_start = 1'b0;
    end
    // ----------
    // Init pulse
    // ----------
    // Held for several cycles so the three-flop pin sync sees it
    task pulse_init(input int n);
        @(posedge clk);
        init_req <= 1'b1;
        repeat (n) @(posedge clk);
        init_req <= 1'b0;
    endtask
    // ----------
    // Bootstrap
    // ----------
    task set_claim(input logic claim, input logic go);
        @(posedge clk);
        bsp_claim_in <= claim;
        ap_start <= go;
    endtask
endmodule
`default_nettype wire

// [prsi_init_state_properties.sv]
// Port checker for the reset and init state loader
`timescale 1ns/1ns
`default_nettype none
module prsi_init_state_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Observed outputs
    input wire logic        fetch_req,
    input wire logic [31:0] fetch_addr_r,
    input wire logic        bsp_claim_out,
    input wire logic        real_mode,
    input wire logic        cache_inval_r
);
    default clocking cb @(posedge clk); endclocking
    // ----------
    // Sequences
    // ----------
    sequence s_no_fetch3;
        !fetch_req [*3];
    endsequence
    // ----------
    // Properties
    // ----------
    inval_set_a: assert property (reset |=> cache_inval_r)
        else $error("cache invalidate not raised in reset");
    inval_clear_a: assert property ($fell(reset) |=> !cache_inval_r)
        else $error("cache invalidate not cleared");
    inval_keep_a: assert property (!reset && !cache_inval_r |=> !cache_inval_r)
        else $error("cache invalidate raised outside reset");
    fetch_hold_a: assert property (reset |-> !fetch_req)
        else $error("fetch allowed during reset");
    real_start_a: assert property (reset |=> real_mode)
        else $error("not in real mode after reset");
    claim_hold_a: assert property (reset |-> !bsp_claim_out)
        else $error("bootstrap claimed during reset");
    claim_fetch_a: assert property (disable iff (reset) $rose(bsp_claim_out) |-> fetch_req)
        else $error("bootstrap without fetch");
    boot_addr_a: assert property (disable iff (reset) $rose(fetch_req) |-> fetch_addr_r == 32'hFFFF_FFF0)
        else $error("first fetch address wrong");
    arb_wait_a: assert property (disable iff (reset) $fell(reset) |-> s_no_fetch3)
        else $error("fetch too soon after release");
endmodule
bind prsi_init_state prsi_init_state_chk u_chk (.clk, .reset, .fetch_req, .fetch_addr_r, .bsp_claim_out,
    .real_mode, .cache_inval_r);
`default_nettype wire

// [prsi_init_state_tb.sv]
// Self-checking testbench for the reset and init state loader
`timescale 1ns/1ns
`default_nettype none
module prsi_init_state_tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        builtin_self_test_fail = 1'b0;
    logic        fetch_done = 1'b0;
    logic [31:0] fetch_next_ip = 32'h0000_0000;
    logic        cs_load = 1'b0;
    logic [15:0] cs_load_sel = 16'h0000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    wire         init_req, bsp_claim_in, ap_start, bsp_claim_out, fetch_req, real_mode, cache_inval_r;
    wire         pready, pslverr;
    wire  [31:0] fetch_addr_r, prdata;
    int          errors = 0;
    int          n_checks = 0;
    logic [31:0] rd;
    logic [31:0] t0;
    logic        er;
    logic [43:0] rows [36];
    always #10 clk = ~clk;
    prsi_sys_model sys (.clk, .init_req, .bsp_claim_in, .ap_start);
    prsi_init_state dut (.clk, .reset, .init_req, .builtin_self_test_fail, .bsp_claim_in, .ap_start, .bsp_claim_out,
        .fetch_req, .fetch_addr_r, .fetch_done, .fetch_next_ip, .cs_load, .cs_load_sel, .real_mode,
        .cache_inval_r, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    // ----------
    // Tasks
    // ----------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Entered just after an edge; ends one idle cycle later so calls may follow at once
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task run(input int lo, input int hi, input logic w);
        for (int i = lo; i < hi; i++) begin
            apb(w, rows[i][43:32], rows[i][31:0]);
            if (!w)
                chk(rd, rows[i][31:0]);
        end
    endtask
    task hard_reset(input logic bf);
        builtin_self_test_fail <= bf;
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask
    task wait_fetch;
        @(negedge clk);
        for (int k = 0; k < 60 && fetch_req !== 1'b1; k++)
            @(negedge clk);
        chk(fetch_req, 1'b1);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #60000;
        errors++;
        wrap_up;
    end
    // ----------
    // Tests
    // ----------
    initial begin
        rows = '{{12'h000, 32'h6000_0010}, {12'h004, 32'h0}, {12'h00C, 32'h0},
            {12'h010, 32'h0}, {12'h014, 32'h2}, {12'h018, 32'h0},
            {12'h01C, 32'h0000_FFF0}, {12'h020, 32'h0000_F000}, {12'h024, 32'hFFFF_0000},
            {12'h028, 32'hFFFF_0FF0}, {12'h02C, 32'h0000_0400}, {12'h03C, 32'h0},
            {12'h040, 32'h0003_0000}, {12'h04C, 32'h0040}, {12'h054, 32'h5555},
            {12'h05C, 32'h8382_929A}, {12'h110, 32'h0321}, {12'h108, 32'h0},
            {12'h100, 32'h0}, {12'h000, 32'h2000_0001}, {12'h04C, 32'h037F},
            {12'h010, 32'h5}, {12'h040, 32'h0004_0000}, {12'h108, 32'hAAAA},
            {12'h030, 32'h1234}, {12'h000, 32'h2000_0010}, {12'h04C, 32'h037F},
            {12'h010, 32'h5}, {12'h040, 32'h0004_0000}, {12'h108, 32'h0},
            {12'h030, 32'h0}, {12'h020, 32'hF000}, {12'h01C, 32'hFFF0},
            {12'h110, 32'h0321}, {12'h100, 32'h0000_0001}, {12'h04C, 32'h0040}};
        @(posedge clk);
        hard_reset(1'b0);
        wait_fetch;
        chk(fetch_addr_r, 32'hFFFF_FFF0);
        chk(bsp_claim_out, 1'b1);
        chk(real_mode, 1'b1);
        chk(cache_inval_r, 1'b0);
        @(posedge clk);
        run(0, 19, 1'b0);
        $display("boot test done");
        apb(1'b0, 12'h044, 32'h0);
        t0 = rd;
        apb(1'b0, 12'h044, 32'h0);
        chk(rd - t0, 32'h0000_0003);
        apb(1'b0, 12'h200, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0000_0000);
        cs_load <= 1'b1;
        cs_load_sel <= 16'h1234;
        @(posedge clk);
        cs_load <= 1'b0;
        fetch_done <= 1'b1;
        fetch_next_ip <= 32'h0001_0010;
        @(posedge clk);
        fetch_done <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(fetch_addr_r, 32'h0001_2350);
        @(posedge clk);
        apb(1'b0, 12'h024, 32'h0);
        chk(rd, 32'h0001_2340);
        $display("fetch test done");
        run(19, 25, 1'b1);
        chk(real_mode, 1'b0);
        cs_load <= 1'b1;
        cs_load_sel <= 16'h0F00;
        @(posedge clk);
        cs_load <= 1'b0;
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h0000_0F00);
        apb(1'b0, 12'h024, 32'h0);
        chk(rd, 32'h0001_2340);
        chk(fetch_addr_r, 32'h0002_2350);
        sys.pulse_init(8);
        @(negedge clk);
        chk(fetch_req, 1'b0);
        chk(cache_inval_r, 1'b0);
        wait_fetch;
        chk(real_mode, 1'b1);
        chk(fetch_addr_r, 32'hFFFF_FFF0);
        @(posedge clk);
        run(25, 34, 1'b0);
        $display("init test done");
        sys.set_claim(1'b1, 1'b0);
        hard_reset(1'b1);
        apb(1'b0, 12'h044, 32'h0);
        chk(rd < 32'h0000_0010, 1'b1);
        run(34, 36, 1'b0);
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(fetch_req, 1'b0);
        chk(bsp_claim_out, 1'b0);
        @(posedge clk);
        sys.set_claim(1'b1, 1'b1);
        wait_fetch;
        chk(bsp_claim_out, 1'b0);
        $display("bootstrap test done");
        wrap_up;
    end
endmodule
`default_nettype wire
